// File: inc/timer_irq_pkg.sv
// Purpose: shared constants and carrier types for the timer and event flag block
// Assumes: byte-wide register port, 12-bit address
// Notes: counter port offsets and the interrupt control reset are local choices

package timer_irq_pkg;
  // register offsets
  localparam logic [11:0] IRQ_CTRL_ADDR = 12'h1e3;
  localparam logic [11:0] MASK_ADDR = 12'h1e4;
  localparam logic [11:0] FLAGS_ADDR = 12'h1e5;
  localparam logic [11:0] SETUP_ADDR = 12'h1e6;
  localparam logic [11:0] CTR0_ADDR = 12'h1e8;
  localparam logic [11:0] CTR1_ADDR = 12'h1e9;
  localparam logic [11:0] CTR2_ADDR = 12'h1ea;
  localparam logic [11:0] CTL_WORD_ADDR = 12'h1eb;

  // event flag bit positions, shared by mask and flags
  localparam int PERR_BIT = 4;
  localparam int SERR_BIT = 3;
  localparam int TC2_BIT = 2;
  localparam int TC1_BIT = 1;
  localparam int TC0_BIT = 0;
  localparam logic [7:0] FLAGS_USED = 8'h1f;

  // interrupt control fields
  localparam int IRQ_EN_BIT = 4;
  localparam logic [7:0] IRQ_CTRL_USED = 8'h1f;
  localparam logic [3:0] INTEN_IDLE = 4'h0;

  // setup register: reserved low two bits
  localparam logic [7:0] SETUP_USED = 8'hfc;

  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h00;

  // internal timer clock: bus clock divided by eight
  localparam int TIMER_CLK_DIV = 8;
  localparam logic [2:0] DIV_LAST = 3'(TIMER_CLK_DIV - 1);

  // counter control word fields
  localparam int CW_SC_HI = 7;
  localparam int CW_SC_LO = 6;
  localparam logic [1:0] SC_READBACK = 2'h3;
  localparam logic [1:0] RW_LATCH = 2'h0;
  localparam logic [1:0] RW_LSB = 2'h1;
  localparam logic [1:0] RW_MSB = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;
  localparam logic [2:0] MODE_TERMINAL = 3'h0;
  localparam logic [2:0] MODE_RATE = 3'h2;
  localparam logic [2:0] MODE_SQUARE = 3'h3;

  // timer clock and gate setup
  typedef struct packed {
    logic counter_two_gate_level;
    logic counter_one_gate_level;
    logic counter_zero_gate_level;
    logic cascade_select;
    logic counter_one_clock_select;
    logic counter_zero_clock_select;
    logic [1:0] rsv;
  } setup_t;

  // one counter's programming strobes
  typedef struct packed {
    logic ctl_wr;
    logic [5:0] ctl;
    logic data_wr;
    logic data_rd;
    logic [7:0] data;
  } ctr_bus_t;
endpackage

// File: src/pin_sync.sv
// Purpose: two-stage synchroniser with rise detector for one pin
// Assumes: pin is asynchronous to sys clock
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // synchronised reset, active low
  input wire logic pin_in, // raw pin level
  output logic level_out, // synchronised level
  output logic rise_out // one-cycle pulse on rising level
);
  logic meta_q, meta_d; // first stage
  logic sync_q, sync_d; // second stage
  logic prev_q, prev_d; // for edge detect

  // next values
  always_comb
  begin
    meta_d = pin_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level_out = sync_q;
  assign rise_out = sync_q & ~prev_q;
endmodule

`default_nettype wire

// File: src/interval_counter.sv
// Purpose: one 16-bit binary down counter with interval-timer programming
// Assumes: tick_in is a one-cycle count enable from the selected source
// Notes: decimal bit is kept but counting is always binary
`timescale 1ns/1ps
`default_nettype none

module interval_counter (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // synchronised reset, active low
  input wire logic tick_in, // count enable pulse
  input wire logic gate_in, // gate level
  input wire timer_irq_pkg::ctr_bus_t bus_in, // programming strobes
  output logic [7:0] rd_data_out, // byte for a data read
  output logic out_out // counter output, registered
);
  logic [2:0] mode_q, mode_d; // counting mode
  logic [1:0] rw_q, rw_d; // byte access format
  logic bcd_q, bcd_d; // stored, never used for counting
  logic [15:0] reload_q, reload_d; // programmed count
  logic [15:0] count_q, count_d; // running count
  logic [15:0] latch_q, latch_d; // latched count
  logic latched_q, latched_d; // latch holds a value
  logic wr_msb_q, wr_msb_d; // next write is high byte
  logic rd_msb_q, rd_msb_d; // next read is high byte
  logic pend_q, pend_d; // load on next tick
  logic armed_q, armed_d; // counting allowed
  logic out_q, out_d; // output level
  logic [15:0] src; // value under read
  logic loaded; // count written fully

  // byte offered to the read port
  always_comb
  begin
    src = latched_q ? latch_q : count_q;
    case (rw_q)
      timer_irq_pkg::RW_MSB: rd_data_out = src[15:8];
      timer_irq_pkg::RW_BOTH: rd_data_out = rd_msb_q ? src[15:8] : src[7:0];
      default: rd_data_out = src[7:0];
    endcase
  end

  // next state of programming and counting
  always_comb
  begin
    mode_d = mode_q;
    rw_d = rw_q;
    bcd_d = bcd_q;
    reload_d = reload_q;
    count_d = count_q;
    latch_d = latch_q;
    latched_d = latched_q;
    wr_msb_d = wr_msb_q;
    rd_msb_d = rd_msb_q;
    pend_d = pend_q;
    armed_d = armed_q;
    out_d = out_q;
    loaded = 1'b0;
    if (bus_in.ctl_wr)
    begin
      if (bus_in.ctl[5:4] == timer_irq_pkg::RW_LATCH)
      begin
        // latch only if not already holding one
        if (!latched_q)
        begin
          latch_d = count_q;
          latched_d = 1'b1;
        end
      end
      else
      begin
        // new mode: stop and wait for a count
        rw_d = bus_in.ctl[5:4];
        mode_d = bus_in.ctl[3:1];
        bcd_d = bus_in.ctl[0];
        out_d = (bus_in.ctl[3:1] != timer_irq_pkg::MODE_TERMINAL);
        armed_d = 1'b0;
        pend_d = 1'b0;
        wr_msb_d = 1'b0;
        rd_msb_d = 1'b0;
        latched_d = 1'b0;
      end
    end
    else if (bus_in.data_wr)
    begin
      case (rw_q)
        timer_irq_pkg::RW_LSB:
        begin
          reload_d = {8'h00, bus_in.data};
          loaded = 1'b1;
        end
        timer_irq_pkg::RW_MSB:
        begin
          reload_d = {bus_in.data, 8'h00};
          loaded = 1'b1;
        end
        default:
        begin
          // low byte first, then high byte completes the count
          if (wr_msb_q)
          begin
            reload_d = {bus_in.data, reload_q[7:0]};
            loaded = 1'b1;
          end
          else
          begin
            reload_d = {reload_q[15:8], bus_in.data};
          end
          wr_msb_d = ~wr_msb_q;
        end
      endcase
      if (loaded)
      begin
        pend_d = 1'b1;
        if (mode_q == timer_irq_pkg::MODE_TERMINAL)
        begin
          out_d = 1'b0;
        end
      end
    end
    else if (bus_in.data_rd)
    begin
      // second byte of a pair, or any single byte, ends a latch
      if (rw_q == timer_irq_pkg::RW_BOTH)
      begin
        rd_msb_d = ~rd_msb_q;
        if (rd_msb_q)
        begin
          latched_d = 1'b0;
        end
      end
      else
      begin
        latched_d = 1'b0;
      end
    end
    if (tick_in)
    begin
      if (pend_q)
      begin
        count_d = reload_q;
        pend_d = 1'b0;
        armed_d = 1'b1;
      end
      else if (armed_q && gate_in)
      begin
        // binary only; a count of zero spans the full range
        count_d = count_q - 16'h0001;
        case (mode_q)
          timer_irq_pkg::MODE_RATE:
          begin
            out_d = (count_q != 16'h0002);
            if (count_q == 16'h0001)
            begin
              count_d = reload_q;
            end
          end
          timer_irq_pkg::MODE_SQUARE:
          begin
            if (count_q == 16'h0001)
            begin
              count_d = reload_q;
            end
            out_d = (count_d > {1'b0, reload_q[15:1]});
          end
          default:
          begin
            // one-shot style: high on terminal count, then stays
            if (count_q == 16'h0001)
            begin
              out_d = 1'b1;
            end
          end
        endcase
      end
    end
  end

  // registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_q <= timer_irq_pkg::MODE_TERMINAL;
      rw_q <= timer_irq_pkg::RW_LSB;
      bcd_q <= 1'b0;
      reload_q <= 16'h0000;
      count_q <= 16'h0000;
      latch_q <= 16'h0000;
      latched_q <= 1'b0;
      wr_msb_q <= 1'b0;
      rd_msb_q <= 1'b0;
      pend_q <= 1'b0;
      armed_q <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      rw_q <= rw_d;
      bcd_q <= bcd_d;
      reload_q <= reload_d;
      count_q <= count_d;
      latch_q <= latch_d;
      latched_q <= latched_d;
      wr_msb_q <= wr_msb_d;
      rd_msb_q <= rd_msb_d;
      pend_q <= pend_d;
      armed_q <= armed_d;
      out_q <= out_d;
    end
  end

  assign out_out = out_q;
endmodule

`default_nettype wire

// File: src/timer_irq_status_logic.sv
// Purpose: three interval counters with clock/gate setup and sticky event flags
// Assumes: sys clock stands for the bus clock; error pins are active low
// Notes: register port answers reads one cycle later, never stalls
//
// What this block does
// - counter output rise sets its flag bit
// - flags stay set until software clears
// - writing one clears flag, zero keeps
// - flags set and read regardless of mask
// - parity error assertion sets flag bit four
// - system error assertion sets flag bit three
// - block itself watches both error lines
// - setup bits seven to five drive gates
// - setup bit four: zero cascades counters
// - cascade: counter one clocks counter two
// - setup bit three picks counter one clock
// - setup bit two picks counter zero clock
// - internal counter clock is bus/8
// - external inputs reach only their own counter
// - counter two uses internal clock unless cascaded
// - three binary 16-bit counters, decimal ignored
// - mask register gates flags onto interrupt
// - control bit four enables interrupt output when control bits three to zero are zero
`timescale 1ns/1ps
`default_nettype none

module timer_irq_status_logic (
  input wire logic sys_clk_in, // 100 MHz system clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic [11:0] addr_in, // register address
  input wire logic [7:0] wr_data_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  input wire logic ext_clock_in_zero_in, // external clock for counter zero
  input wire logic ext_clock_in_one_in, // external clock for counter one
  input wire logic parity_err_b_in, // bus parity error pin, active low
  input wire logic system_err_b_in, // bus system error pin, active low
  output logic [7:0] rd_data_out, // read data, cycle after strobe
  output logic irq_out, // interrupt request, active high
  output logic [2:0] counter_out_out // counter output levels
);
  logic rst_meta_q; // reset release, first stage
  logic rst_n_q; // reset release, used everywhere
  logic [7:0] flags_q, flags_d; // interrupt_event_flags
  logic [7:0] mask_q, mask_d; // interrupt_source_mask
  logic [7:0] ctrl_q, ctrl_d; // interrupt control
  timer_irq_pkg::setup_t setup_q, setup_d; // timer_clock_gate_setup
  logic [2:0] div_q, div_d; // internal clock divider
  logic div_tick; // internal clock tick
  logic [2:0] tout_prev_q, tout_prev_d; // previous counter outputs
  logic [2:0] tout; // counter outputs
  logic [2:0] tout_rise; // rising counter outputs
  logic [7:0] rd_q, rd_d; // read data register
  logic irq_q, irq_d; // interrupt output register
  logic ext0_rise, ext1_rise; // external clock edges
  logic perr_lvl, serr_lvl; // synchronised error pins
  logic [2:0] tick; // per-counter count enable
  logic [2:0] gate; // per-counter gate level
  logic [7:0] ctr_rd [3]; // per-counter read bytes
  timer_irq_pkg::ctr_bus_t ctr_bus [3]; // per-counter strobes
  logic [7:0] set_bits; // events this cycle
  logic flags_wr; // write to flag register

  // reset release through two flops; assertion is immediate
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // pin synchronisers
  pin_sync u_ext0 (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_q),
    .pin_in(ext_clock_in_zero_in),
    .level_out(),
    .rise_out(ext0_rise)
  );

  pin_sync u_ext1 (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_q),
    .pin_in(ext_clock_in_one_in),
    .level_out(),
    .rise_out(ext1_rise)
  );

  // error pins inverted so the synchronised level is high when asserted
  pin_sync u_perr (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_q),
    .pin_in(~parity_err_b_in),
    .level_out(perr_lvl),
    .rise_out()
  );

  pin_sync u_serr (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_q),
    .pin_in(~system_err_b_in),
    .level_out(serr_lvl),
    .rise_out()
  );

  // clock source and gate routing
  always_comb
  begin
    div_d = (div_q == timer_irq_pkg::DIV_LAST) ? 3'h0 : div_q + 3'h1;
    div_tick = (div_q == timer_irq_pkg::DIV_LAST);
    // each external input feeds only its own counter
    tick[0] = setup_q.counter_zero_clock_select ? div_tick : ext0_rise;
    tick[1] = setup_q.counter_one_clock_select ? div_tick : ext1_rise;
    // cascade when the select is zero: counter one's output clocks counter two
    tick[2] = setup_q.cascade_select ? div_tick : tout_rise[1];
    gate[0] = setup_q.counter_zero_gate_level;
    gate[1] = setup_q.counter_one_gate_level;
    gate[2] = setup_q.counter_two_gate_level;
  end

  // programming strobes per counter; read-back selector is ignored
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      ctr_bus[i].ctl_wr = wr_in && (addr_in == timer_irq_pkg::CTL_WORD_ADDR)
        && (wr_data_in[timer_irq_pkg::CW_SC_HI:timer_irq_pkg::CW_SC_LO] == 2'(i));
      ctr_bus[i].ctl = wr_data_in[5:0];
      ctr_bus[i].data = wr_data_in;
      ctr_bus[i].data_wr = wr_in && (addr_in == timer_irq_pkg::CTR0_ADDR + 12'(i));
      ctr_bus[i].data_rd = rd_in && (addr_in == timer_irq_pkg::CTR0_ADDR + 12'(i));
    end
  end

  // three independent counters
  for (genvar g = 0; g < 3; g++)
  begin : g_ctr
    interval_counter u_ctr (
      .clk_in(sys_clk_in),
      .rst_n_in(rst_n_q),
      .tick_in(tick[g]),
      .gate_in(gate[g]),
      .bus_in(ctr_bus[g]),
      .rd_data_out(ctr_rd[g]),
      .out_out(tout[g])
    );
  end

  assign tout_rise = tout & ~tout_prev_q;

  // register writes, flag updates, read data and interrupt
  always_comb
  begin
    tout_prev_d = tout;
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    setup_d = setup_q;
    flags_wr = wr_in && (addr_in == timer_irq_pkg::FLAGS_ADDR);
    // events enter regardless of mask
    set_bits = 8'h00;
    set_bits[timer_irq_pkg::TC0_BIT] = tout_rise[0];
    set_bits[timer_irq_pkg::TC1_BIT] = tout_rise[1];
    set_bits[timer_irq_pkg::TC2_BIT] = tout_rise[2];
    // level watch: flag re-sets while the line stays asserted
    set_bits[timer_irq_pkg::PERR_BIT] = perr_lvl;
    set_bits[timer_irq_pkg::SERR_BIT] = serr_lvl;
    // sticky; a one clears, a zero keeps; a new event beats the clear
    flags_d = flags_q;
    if (flags_wr)
    begin
      flags_d = flags_q & ~wr_data_in;
    end
    flags_d = (flags_d | set_bits) & timer_irq_pkg::FLAGS_USED;
    if (wr_in)
    begin
      case (addr_in)
        timer_irq_pkg::MASK_ADDR: mask_d = wr_data_in & timer_irq_pkg::FLAGS_USED;
        timer_irq_pkg::IRQ_CTRL_ADDR: ctrl_d = wr_data_in & timer_irq_pkg::IRQ_CTRL_USED;
        // reserved low bits are dropped so they read zero
        timer_irq_pkg::SETUP_ADDR: setup_d = wr_data_in & timer_irq_pkg::SETUP_USED;
        default: ;
      endcase
    end
    // read data stands only in the cycle after the strobe
    rd_d = 8'h00;
    if (rd_in)
    begin
      case (addr_in)
        timer_irq_pkg::IRQ_CTRL_ADDR: rd_d = ctrl_q;
        timer_irq_pkg::MASK_ADDR: rd_d = mask_q;
        timer_irq_pkg::FLAGS_ADDR: rd_d = flags_q;
        timer_irq_pkg::SETUP_ADDR: rd_d = setup_q;
        timer_irq_pkg::CTR0_ADDR: rd_d = ctr_rd[0];
        timer_irq_pkg::CTR1_ADDR: rd_d = ctr_rd[1];
        timer_irq_pkg::CTR2_ADDR: rd_d = ctr_rd[2];
        default: rd_d = 8'h00;
      endcase
    end
    // any nonzero select field also holds the request off
    irq_d = ctrl_q[timer_irq_pkg::IRQ_EN_BIT]
      && (ctrl_q[3:0] == timer_irq_pkg::INTEN_IDLE)
      && ((flags_q & mask_q) != 8'h00);
  end

  // registers
  always_ff @(posedge sys_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      flags_q <= timer_irq_pkg::FLAGS_RST;
      mask_q <= timer_irq_pkg::MASK_RST;
      ctrl_q <= timer_irq_pkg::IRQ_CTRL_RST;
      setup_q <= timer_irq_pkg::SETUP_RST;
      div_q <= 3'h0;
      tout_prev_q <= 3'h0;
      rd_q <= 8'h00;
      irq_q <= 1'b0;
    end
    else
    begin
      flags_q <= flags_d;
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
      setup_q <= setup_d;
      div_q <= div_d;
      tout_prev_q <= tout_prev_d;
      rd_q <= rd_d;
      irq_q <= irq_d;
    end
  end

  assign rd_data_out = rd_q;
  assign irq_out = irq_q;
  assign counter_out_out = tout;
endmodule

`default_nettype wire

// File: sim/timer_irq_checker.sv
// Purpose: port-level assertions for the timer and event flag block
// Assumes: one clock domain, error pins active low, reads answer one cycle later
// Notes: flags are only visible through reads, so checks ride on reads
`timescale 1ns/1ps
`default_nettype none

module timer_irq_checker (
  input wire logic sys_clk_in, // system clock
  input wire logic rst_b_in, // reset, active low
  input wire logic [11:0] addr_in, // register address
  input wire logic [7:0] wr_data_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  input wire logic parity_err_b_in, // parity error pin
  input wire logic system_err_b_in, // system error pin
  input wire logic [7:0] rd_data_out, // read data
  input wire logic [2:0] counter_out_out // counter outputs
);
  localparam logic [11:0] FLG = timer_irq_pkg::FLAGS_ADDR; // flags offset
  localparam logic [11:0] SET = timer_irq_pkg::SETUP_ADDR; // setup offset

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // eight low cycles cover reset lift plus the pin synchroniser
  perr_flag_a : assert property ((!parity_err_b_in)[*8] ##0 (rd_in && addr_in == FLG) |=> rd_data_out[4])
    else $error("parity flag not seen");
  serr_flag_a : assert property ((!system_err_b_in)[*8] ##0 (rd_in && addr_in == FLG) |=> rd_data_out[3])
    else $error("system error flag not seen");
  tc_zero_a : assert property ($rose(counter_out_out[0]) ##1 (rd_in && addr_in == FLG) |=> rd_data_out[0])
    else $error("counter zero rise not flagged");
  tc_two_a : assert property ($rose(counter_out_out[2]) ##1 (rd_in && addr_in == FLG) |=> rd_data_out[2])
    else $error("counter two rise not flagged");
  // back-to-back reads: nothing may clear a flag between them
  flag_sticky_a : assert property ((rd_in && addr_in == FLG) ##1 (rd_in && addr_in == FLG)
    |=> ((rd_data_out & $past(rd_data_out)) == $past(rd_data_out)))
    else $error("flag dropped without a clear");
  w1c_clear_a : assert property (parity_err_b_in[*5] ##0 (wr_in && addr_in == FLG && wr_data_in[4])
    ##2 (rd_in && addr_in == FLG) |=> !rd_data_out[4])
    else $error("flag not cleared by writing one");
  flags_rsv_a : assert property (rd_in && addr_in == FLG |=> rd_data_out[7:5] == 3'h0)
    else $error("flags reserved bits not zero");
  setup_rsv_a : assert property (rd_in && addr_in == SET |=> rd_data_out[1:0] == 2'h0)
    else $error("setup reserved bits not zero");
  setup_back_a : assert property ((wr_in && addr_in == SET) ##2 (rd_in && addr_in == SET)
    |=> rd_data_out[7:2] == $past(wr_data_in[7:2], 3))
    else $error("setup bits not read back");
endmodule

`default_nettype wire

// File: sim/pin_stimulus.sv
// Purpose: model of the connector clocks and the bus error lines
// Assumes: bench asks for clocks and error assertions by level
// Notes: external clocks stand low when stopped, error lines idle high
`timescale 1ns/1ps
`default_nettype none

module pin_stimulus (
  input wire logic clk_in, // bench clock
  input wire logic run_zero_in, // run first external clock
  input wire logic run_one_in, // run second external clock
  input wire logic perr_req_in, // hold parity error asserted
  input wire logic serr_req_in, // hold system error asserted
  output logic ext_zero_out, // first external clock
  output logic ext_one_out, // second external clock
  output logic perr_b_out, // parity error line, active low
  output logic serr_b_out // system error line, active low
);
  logic [1:0] div_q = 2'h0; // slows the external clocks to one eighth
  logic ext0_q = 1'b0, ext1_q = 1'b0; // clock levels, one driver each

  // square wave while running, parked low otherwise
  always @(posedge clk_in)
  begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3)
    begin
      ext0_q <= run_zero_in & ~ext0_q;
      ext1_q <= run_one_in & ~ext1_q;
    end
  end

  assign ext_zero_out = ext0_q;
  assign ext_one_out = ext1_q;

  // pulled-up lines, low only while asserted
  assign perr_b_out = ~perr_req_in;
  assign serr_b_out = ~serr_req_in;
endmodule

`default_nettype wire

// File: sim/timer_irq_status_logic_tb_top.sv
// Purpose: self-checking bench for the timer and event flag block
// Assumes: byte register port with one cycle read latency
// Notes: counts in cycles of the 100 MHz clock, internal tick every eight
`timescale 1ns/1ps
`default_nettype none

module timer_irq_status_logic_tb_top;
  logic sys_clk = 1'b0; // bench clock
  logic rst_b = 1'b0; // reset, active low
  logic [11:0] addr = 12'h000; // register address
  logic [7:0] wdat = 8'h00; // write data
  logic wr = 1'b0; // write strobe
  logic rd = 1'b0; // read strobe
  logic run0 = 1'b0, run1 = 1'b0, perr = 1'b0, serr = 1'b0; // pin model requests
  logic ext0, ext1, perr_b, serr_b; // pin levels
  logic [7:0] rdat; // read data
  logic irq; // interrupt level
  logic [2:0] cnt_out; // counter outputs
  logic [7:0] v; // scratch read value
  int miscompares = 0; // mismatches
  int n_tests = 0; // comparisons
  int n; // cycles waited

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  timer_irq_status_logic u_dut (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .addr_in(addr), .wr_data_in(wdat),
    .wr_in(wr), .rd_in(rd), .ext_clock_in_zero_in(ext0), .ext_clock_in_one_in(ext1), .parity_err_b_in(perr_b),
    .system_err_b_in(serr_b), .rd_data_out(rdat), .irq_out(irq), .counter_out_out(cnt_out));

  pin_stimulus u_pins (.clk_in(sys_clk), .run_zero_in(run0), .run_one_in(run1), .perr_req_in(perr),
    .serr_req_in(serr), .ext_zero_out(ext0), .ext_one_out(ext1), .perr_b_out(perr_b), .serr_b_out(serr_b));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  // one-cycle write strobe
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask

  task automatic chk_reg(input string what, input logic [11:0] a, input logic [7:0] exp);
    rd_reg(a, v);
    chk(what, exp, v);
  endtask

  // bounded wait for a counter output to rise
  task automatic wait_out(input int idx, input int lim);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    while (cnt_out[idx] !== 1'b1 && n < lim);
  endtask

  task automatic t_setup;
    chk_reg("flags after reset", timer_irq_pkg::FLAGS_ADDR, 8'h00);
    wr_reg(timer_irq_pkg::SETUP_ADDR, 8'hff);
    chk_reg("setup readback", timer_irq_pkg::SETUP_ADDR, 8'hfc);
    wr_reg(timer_irq_pkg::SETUP_ADDR, 8'h00);
    chk_reg("setup cleared", timer_irq_pkg::SETUP_ADDR, 8'h00);
    chk_reg("unmapped read", 12'h1e7, 8'h00);
  endtask

  // error line assertion with mask left at zero
  task automatic t_error(input int b);
    logic [7:0] bit_v;
    bit_v = 8'h01 << b;
    if (b == 4) perr <= 1'b1;
    else serr <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk_reg("error flag held", timer_irq_pkg::FLAGS_ADDR, bit_v);
    perr <= 1'b0;
    serr <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk_reg("error flag", timer_irq_pkg::FLAGS_ADDR, bit_v);
    // two reads back to back
    @(posedge sys_clk);
    addr <= timer_irq_pkg::FLAGS_ADDR;
    rd <= 1'b1;
    @(posedge sys_clk);
    #1 chk("first of pair", bit_v, rdat);
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk("second of pair", bit_v, rdat);
    wr_reg(timer_irq_pkg::FLAGS_ADDR, 8'h1f & ~bit_v);
    chk_reg("zero keeps flag", timer_irq_pkg::FLAGS_ADDR, bit_v);
    wr_reg(timer_irq_pkg::FLAGS_ADDR, bit_v);
    chk_reg("one clears flag", timer_irq_pkg::FLAGS_ADDR, 8'h00);
  endtask

  // count 0x10 on the divided clock: binary gives 16 ticks, decimal would give 10
  task automatic t_count_zero;
    wr_reg(timer_irq_pkg::SETUP_ADDR, 8'h34);
    wr_reg(timer_irq_pkg::CTL_WORD_ADDR, 8'h31);
    wr_reg(timer_irq_pkg::CTR0_ADDR, 8'h10);
    wr_reg(timer_irq_pkg::CTR0_ADDR, 8'h00);
    wait_out(0, 400);
    chk("counter zero span", 8'h01, {7'h00, (n >= 16 * 8) && (n <= 19 * 8)});
    chk_reg("counter zero flag", timer_irq_pkg::FLAGS_ADDR, 8'h01);
  endtask

  // counter one on its own connector clock only
  task automatic t_ext_one;
    wr_reg(timer_irq_pkg::SETUP_ADDR, 8'h50);
    wr_reg(timer_irq_pkg::CTL_WORD_ADDR, 8'h70);
    wr_reg(timer_irq_pkg::CTR1_ADDR, 8'h03);
    wr_reg(timer_irq_pkg::CTR1_ADDR, 8'h00);
    run0 <= 1'b1;
    wait_out(1, 200);
    chk("counter one idle", 8'h00, {7'h00, cnt_out[1]});
    run1 <= 1'b1;
    wait_out(1, 400);
    chk("counter one ran", 8'h01, {7'h00, cnt_out[1]});
    run0 <= 1'b0;
    run1 <= 1'b0;
    chk_reg("counter one flag", timer_irq_pkg::FLAGS_ADDR, 8'h03);
  endtask

  // counter two fed by counter one rises, slower than the divided clock
  task automatic t_cascade;
    wr_reg(timer_irq_pkg::FLAGS_ADDR, 8'h1f);
    wr_reg(timer_irq_pkg::SETUP_ADDR, 8'hc8);
    wr_reg(timer_irq_pkg::CTL_WORD_ADDR, 8'hb0);
    wr_reg(timer_irq_pkg::CTR2_ADDR, 8'h03);
    wr_reg(timer_irq_pkg::CTR2_ADDR, 8'h00);
    wr_reg(timer_irq_pkg::CTL_WORD_ADDR, 8'h74);
    wr_reg(timer_irq_pkg::CTR1_ADDR, 8'h02);
    wr_reg(timer_irq_pkg::CTR1_ADDR, 8'h00);
    wait_out(2, 400);
    chk("cascade span", 8'h01, {7'h00, (n >= 32) && (cnt_out[2] === 1'b1)});
    rd_reg(timer_irq_pkg::FLAGS_ADDR, v);
    chk("counter two flag", 8'h04, v & 8'h04);
  endtask

  task automatic t_irq;
    wr_reg(timer_irq_pkg::MASK_ADDR, 8'h1f);
    wr_reg(timer_irq_pkg::IRQ_CTRL_ADDR, 8'h10);
    repeat (3) @(posedge sys_clk);
    #1 chk("irq enabled", 8'h01, {7'h00, irq});
    wr_reg(timer_irq_pkg::MASK_ADDR, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1 chk("irq masked", 8'h00, {7'h00, irq});
    wr_reg(timer_irq_pkg::MASK_ADDR, 8'h1f);
    wr_reg(timer_irq_pkg::IRQ_CTRL_ADDR, 8'h11);
    repeat (3) @(posedge sys_clk);
    #1 chk("irq blocked", 8'h00, {7'h00, irq});
    wr_reg(timer_irq_pkg::IRQ_CTRL_ADDR, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1 chk("irq off", 8'h00, {7'h00, irq});
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_setup;
    t_error(4);
    t_error(3);
    t_count_zero;
    t_ext_one;
    t_cascade;
    t_irq;
    conclude;
  end

  // watchdog far past the run's length
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    conclude;
  end
endmodule

bind timer_irq_status_logic timer_irq_checker u_chk (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .parity_err_b_in(parity_err_b_in),
  .system_err_b_in(system_err_b_in), .rd_data_out(rd_data_out), .counter_out_out(counter_out_out));

`default_nettype wire
